// ===== rtl/lpm_loop_map.sv
`timescale 1ns/10ps
`default_nettype none
module lpm_loop_map
#(
	parameter int LOOPS = lpm_pkg::NUM_LOOPS
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Switches
	input wire logic [6:0] unit_number,
	input wire logic [3:0] input_type,
	input wire logic temp_unit_sw,
	input wire logic data_format_sw,
	// Measurement side
	input wire logic [LOOPS*16-1:0] meas_raw,
	input wire logic [LOOPS-1:0] meas_valid,
	input wire logic [LOOPS-1:0] ctrl_demand,
	input wire logic control_stopped,
	input wire logic init_error,
	input wire logic host_error,
	// Host word window read port
	input wire logic [4:0] rd_offset,
	output logic [15:0] rd_data,
	output logic [15:0] io_base,
	output logic [31:0] dm_base,
	output logic fahrenheit,
	output logic bcd_mode,
	output logic k_low_range,
	// Lamps and outputs
	output logic run_lamp,
	output logic unit_fault_lamp,
	output logic host_fault_lamp,
	output logic [LOOPS-1:0] ctrl_out,
	output logic [LOOPS-1:0] out_lamp
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [4:0] pv_ofs(input int i);
		case (i)
			0: pv_ofs = lpm_pkg::OFS_PV1;
			1: pv_ofs = lpm_pkg::OFS_PV2;
			2: pv_ofs = lpm_pkg::OFS_PV3;
			default: pv_ofs = lpm_pkg::OFS_PV4;
		endcase
	endfunction
	function automatic logic [4:0] st_ofs(input int i);
		case (i)
			0: st_ofs = lpm_pkg::OFS_ST1;
			1: st_ofs = lpm_pkg::OFS_ST2;
			2: st_ofs = lpm_pkg::OFS_ST3;
			default: st_ofs = lpm_pkg::OFS_ST4;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Per-loop measurement state
	logic [15:0] pv_q [LOOPS];
	logic [15:0] pv_d [LOOPS];
	logic [LOOPS-1:0] err_q;
	logic [LOOPS-1:0] err_d;
	logic [LOOPS-1:0] chk_err;
	logic [LOOPS-1:0] chk_upd;
	logic [15:0] chk_pv [LOOPS];
	// Control outputs and lamps
	logic [LOOPS-1:0] ctrl_q;
	logic [LOOPS-1:0] ctrl_d;
	logic [LOOPS-1:0] out_lamp_q;
	logic [LOOPS-1:0] out_lamp_d;
	logic run_q;
	logic run_d;
	logic ufault_q;
	logic ufault_d;
	logic hfault_q;
	logic hfault_d;
	// Window bases and switch decodes
	logic [15:0] io_base_q;
	logic [15:0] io_base_d;
	logic [31:0] dm_base_q;
	logic [31:0] dm_base_d;
	logic fahr_q;
	logic fahr_d;
	logic bcd_q;
	logic bcd_d;
	logic klow_q;
	logic klow_d;
	// Host read port
	logic [15:0] rd_data_q;
	logic [15:0] rd_data_d;

	for (genvar g = 0; g < LOOPS; g++)
	begin : g_chk
		lpm_meas_if mi ();
		assign mi.raw = meas_raw[g*16 +: 16];
		assign mi.valid = meas_valid[g];
		assign mi.bcd = ~data_format_sw;
		assign mi.input_type = input_type;
		assign chk_pv[g] = mi.pv;
		assign chk_err[g] = mi.err;
		assign chk_upd[g] = mi.update;
		lpm_range_check u_chk (.m(mi));
	end

	////////////////////////////////////////////////////////////////////////
	// Measurement store
	always_comb
	begin
		for (int i = 0; i < LOOPS; i++)
		begin
			pv_d[i] = pv_q[i];
			err_d[i] = err_q[i];
			// A good reading clears the flag, so a recovered sensor needs no host action
			if (chk_upd[i])
			begin
				pv_d[i] = chk_pv[i];
				err_d[i] = chk_err[i];
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			for (int i = 0; i < LOOPS; i++)
				pv_q[i] <= lpm_pkg::PV_RESET;
			err_q <= '0;
		end
		else
		begin
			pv_q <= pv_d;
			err_q <= err_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control outputs and lamps
	always_comb
	begin
		// Gated by the flag being stored now, so a faulty loop never drives its output
		ctrl_d = ctrl_demand & ~err_d & {LOOPS{~control_stopped}};
		out_lamp_d = ctrl_d;
		run_d = ~control_stopped;
		ufault_d = (|err_d) | init_error;
		hfault_d = host_error;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ctrl_q <= '0;
			out_lamp_q <= '0;
			run_q <= 1'b0;
			ufault_q <= 1'b0;
			hfault_q <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			out_lamp_q <= out_lamp_d;
			run_q <= run_d;
			ufault_q <= ufault_d;
			hfault_q <= hfault_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Window bases and switch decodes
	always_comb
	begin
		// Tracks the unit switch live; the host sees a change one cycle later
		io_base_d = 16'(lpm_pkg::IO_AREA_BASE + 16'(unit_number) * lpm_pkg::IO_WORDS_PER_UNIT);
		dm_base_d = lpm_pkg::DM_AREA_BASE + 32'(unit_number) * lpm_pkg::DM_WORDS_PER_UNIT;
		fahr_d = temp_unit_sw;
		bcd_d = ~data_format_sw;
		klow_d = (input_type == lpm_pkg::INPUT_K_0_500);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			io_base_q <= lpm_pkg::IO_AREA_BASE;
			dm_base_q <= lpm_pkg::DM_AREA_BASE;
			fahr_q <= 1'b0;
			bcd_q <= 1'b1;
			klow_q <= 1'b0;
		end
		else
		begin
			io_base_q <= io_base_d;
			dm_base_q <= dm_base_d;
			fahr_q <= fahr_d;
			bcd_q <= bcd_d;
			klow_q <= klow_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Host read port
	always_comb
	begin
		// Unmapped words read as zero; a status word carries only its flag bit
		rd_data_d = lpm_pkg::WORD_ZERO;
		for (int i = 0; i < LOOPS; i++)
		begin
			if (rd_offset == pv_ofs(i))
				rd_data_d = pv_q[i];
			else if (rd_offset == st_ofs(i))
				rd_data_d[lpm_pkg::SENSOR_ERR_BIT] = err_q[i];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			rd_data_q <= lpm_pkg::WORD_ZERO;
		else
			rd_data_q <= rd_data_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Every output is taken straight from its register
	assign rd_data = rd_data_q;
	assign io_base = io_base_q;
	assign dm_base = dm_base_q;
	assign fahrenheit = fahr_q;
	assign bcd_mode = bcd_q;
	assign k_low_range = klow_q;
	assign run_lamp = run_q;
	assign unit_fault_lamp = ufault_q;
	assign host_fault_lamp = hfault_q;
	assign ctrl_out = ctrl_q;
	assign out_lamp = out_lamp_q;

	////////////////////////////////////////////////////////////////////////
	unit_one_map_a: assert property (@(posedge mclk) disable iff (rst)
		unit_number == lpm_pkg::UNIT_ONE |=> io_base == 16'h07da && dm_base == 32'h00004e84)
		else $error("unit one window wrong");
	pv_read_a: assert property (@(posedge mclk) disable iff (rst)
		rd_offset == lpm_pkg::OFS_PV3 |=> rd_data == $past(pv_q[2]))
		else $error("loop 3 value misplaced");
	pv4_read_a: assert property (@(posedge mclk) disable iff (rst)
		rd_offset == lpm_pkg::OFS_PV4 |=> rd_data == $past(pv_q[3]))
		else $error("loop 4 value misplaced");
	err_read_a: assert property (@(posedge mclk) disable iff (rst)
		rd_offset == lpm_pkg::OFS_ST2 |=> rd_data[lpm_pkg::SENSOR_ERR_BIT] == $past(err_q[1]))
		else $error("loop 2 flag misplaced");
	err4_read_a: assert property (@(posedge mclk) disable iff (rst)
		rd_offset == lpm_pkg::OFS_ST4 |=> rd_data[lpm_pkg::SENSOR_ERR_BIT] == $past(err_q[3]))
		else $error("loop 4 flag misplaced");
	ktype_a: assert property (@(posedge mclk) disable iff (rst)
		input_type == lpm_pkg::INPUT_K_0_500 |=> k_low_range)
		else $error("input type 1 not decoded");
	k_other_a: assert property (@(posedge mclk) disable iff (rst)
		input_type != lpm_pkg::INPUT_K_0_500 |=> !k_low_range)
		else $error("other input type decoded as 1");
	switch_off_a: assert property (@(posedge mclk) disable iff (rst)
		!temp_unit_sw && !data_format_sw |=> !fahrenheit && bcd_mode)
		else $error("switch defaults wrong");
	run_lamp_a: assert property (@(posedge mclk) disable iff (rst)
		control_stopped |=> !run_lamp && ctrl_out == '0)
		else $error("run lamp lit while stopped");
	run_on_a: assert property (@(posedge mclk) disable iff (rst)
		!control_stopped |=> run_lamp)
		else $error("run lamp dark while running");
	unit_fault_a: assert property (@(posedge mclk) disable iff (rst)
		(|err_q) |-> unit_fault_lamp)
		else $error("unit fault lamp missed");
	init_fault_a: assert property (@(posedge mclk) disable iff (rst)
		init_error |=> unit_fault_lamp)
		else $error("init error not shown");
	fault_dark_a: assert property (@(posedge mclk) disable iff (rst)
		!init_error && err_d == '0 |=> !unit_fault_lamp)
		else $error("unit fault lamp lit falsely");
	host_fault_a: assert property (@(posedge mclk) disable iff (rst)
		host_error |=> host_fault_lamp)
		else $error("host fault lamp missed");
	host_dark_a: assert property (@(posedge mclk) disable iff (rst)
		!host_error |=> !host_fault_lamp)
		else $error("host fault lamp lit falsely");
	out_lamp_a: assert property (@(posedge mclk) disable iff (rst)
		out_lamp == ctrl_out)
		else $error("output lamp mismatch");
	sensor_err_a: assert property (@(posedge mclk) disable iff (rst)
		meas_valid[0] && chk_err[0] |=> err_q[0] && pv_q[0] == lpm_pkg::PV_FAULT_PATTERN && !ctrl_out[0])
		else $error("out of range not handled");
	refresh_a: assert property (@(posedge mclk) disable iff (rst)
		meas_valid[1] |=> pv_q[1] == $past(chk_pv[1]))
		else $error("value not refreshed");
	good_reading_a: assert property (@(posedge mclk) disable iff (rst)
		meas_valid[0] && !chk_err[0] |=> !err_q[0] && pv_q[0] == $past(meas_raw[15:0]))
		else $error("good reading not stored");
endmodule
`default_nettype wire

// ===== rtl/lpm_pkg.sv
package lpm_pkg;
	localparam int NUM_LOOPS = 4;
	localparam logic [6:0] UNIT_ONE = 7'h01;
	localparam logic [15:0] IO_AREA_BASE = 16'h07d0;
	localparam logic [15:0] IO_WORDS_PER_UNIT = 16'h000a;
	localparam logic [15:0] IO_WINDOW_WORDS = 16'h0014;
	localparam logic [31:0] DM_AREA_BASE = 32'h00004e20;
	localparam logic [31:0] DM_WORDS_PER_UNIT = 32'h00000064;
	localparam logic [31:0] DM_WINDOW_WORDS = 32'h00000064;
	localparam logic [4:0] OFS_PV1 = 5'h03;
	localparam logic [4:0] OFS_PV2 = 5'h04;
	localparam logic [4:0] OFS_ST1 = 5'h08;
	localparam logic [4:0] OFS_ST2 = 5'h09;
	localparam logic [4:0] OFS_PV3 = 5'h0d;
	localparam logic [4:0] OFS_PV4 = 5'h0e;
	localparam logic [4:0] OFS_ST3 = 5'h12;
	localparam logic [4:0] OFS_ST4 = 5'h13;
	localparam int SENSOR_ERR_BIT = 14;
	localparam logic [15:0] PV_FAULT_PATTERN = 16'hcccc;
	localparam logic [15:0] PV_RESET = 16'h0000;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [3:0] INPUT_K_0_500 = 4'h1;
	localparam logic [15:0] K_0_500_BIN_HI = 16'h1388;
	localparam logic [15:0] K_0_500_BCD_HI = 16'h5000;
	localparam logic [15:0] K_0_500_LO = 16'h0000;
	localparam logic [15:0] RANGE_MARGIN_BIN = 16'h00c8;
	localparam logic [15:0] RANGE_MARGIN_BCD = 16'h0200;
endpackage

// ===== rtl/lpm_meas_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lpm_meas_if;
	logic [15:0] raw;
	logic valid;
	logic bcd;
	logic [3:0] input_type;
	logic [15:0] pv;
	logic err;
	logic update;
	modport src (output raw, output valid, output bcd, output input_type, input pv, input err, input update);
	modport chk (input raw, input valid, input bcd, input input_type, output pv, output err, output update);
endinterface
`default_nettype wire

// ===== rtl/lpm_range_check.sv
`timescale 1ns/10ps
`default_nettype none
module lpm_range_check
(
	lpm_meas_if.chk m
);
	logic [15:0] hi_lim;
	logic over;
	always_comb
	begin
		hi_lim = lpm_pkg::K_0_500_BIN_HI;
		if (m.input_type == lpm_pkg::INPUT_K_0_500)
		begin
			// Indication range reaches somewhat past the setting range
			if (m.bcd)
				hi_lim = lpm_pkg::K_0_500_BCD_HI + lpm_pkg::RANGE_MARGIN_BCD;
			else
				hi_lim = lpm_pkg::K_0_500_BIN_HI + lpm_pkg::RANGE_MARGIN_BIN;
		end
		else
			hi_lim = 16'hffff;
		over = m.raw > hi_lim;
		m.err = m.valid & over;
		m.pv = over ? lpm_pkg::PV_FAULT_PATTERN : m.raw;
		m.update = m.valid;
	end
endmodule
`default_nettype wire

// ===== verification/lpm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module lpm_host_model
(
	// Clock
	input wire logic mclk,
	// Word window read port
	output logic [4:0] rd_offset,
	input wire logic [15:0] rd_data
);
	initial rd_offset = 5'h00;
	// Offset launched off the falling edge; the word is taken at the next falling edge
	task automatic read(input logic [4:0] off, output logic [15:0] word);
		if (off > 5'h13)
			off = 5'h00; // Host stays inside its twenty words
		@(negedge mclk);
		rd_offset = off;
		@(posedge mclk);
		@(negedge mclk);
		word = rd_data;
	endtask
endmodule
`default_nettype wire

// ===== verification/loop_pv_map_and_status_lamps_tb.sv
`timescale 1ns/10ps
`default_nettype none
module loop_pv_map_and_status_lamps_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [6:0] unit_number = 7'h01;
	logic [3:0] input_type = lpm_pkg::INPUT_K_0_500;
	logic temp_unit_sw = 1'b0;
	logic data_format_sw = 1'b0;
	logic [63:0] meas_raw = 64'h0;
	logic [3:0] meas_valid = 4'h0;
	logic [3:0] ctrl_demand = 4'h0;
	logic control_stopped = 1'b0;
	logic init_error = 1'b0;
	logic host_error = 1'b0;
	logic [4:0] rd_offset;
	logic [15:0] rd_data, io_base;
	logic [31:0] dm_base;
	logic fahrenheit, bcd_mode, k_low_range, run_lamp, unit_fault_lamp, host_fault_lamp;
	logic [3:0] ctrl_out, out_lamp;
	logic [3:0] errs = 4'h0;
	int n_errors = 0;
	int checked = 0;
	logic [31:0] seed = 32'd29468;
	logic [4:0] pv_ofs [4] = '{lpm_pkg::OFS_PV1, lpm_pkg::OFS_PV2, lpm_pkg::OFS_PV3, lpm_pkg::OFS_PV4};
	logic [4:0] st_ofs [4] = '{lpm_pkg::OFS_ST1, lpm_pkg::OFS_ST2, lpm_pkg::OFS_ST3, lpm_pkg::OFS_ST4};
	always #2 mclk = ~mclk;
	lpm_loop_map lpm_loop_map_i (.mclk, .rst, .unit_number, .input_type, .temp_unit_sw, .data_format_sw,
		.meas_raw, .meas_valid, .ctrl_demand, .control_stopped, .init_error, .host_error, .rd_offset, .rd_data,
		.io_base, .dm_base, .fahrenheit, .bcd_mode, .k_low_range, .run_lamp, .unit_fault_lamp, .host_fault_lamp,
		.ctrl_out, .out_lamp);
	lpm_host_model lpm_host_model_i (.mclk, .rd_offset, .rd_data);
	////////////////////////////////////////
	function automatic logic [31:0] nxt();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Only input type 1 has a bounded indication range; its limit follows the data format
	function automatic logic over(input logic [15:0] raw);
		if (input_type != lpm_pkg::INPUT_K_0_500)
			return 1'b0;
		if (data_format_sw)
			return raw > (lpm_pkg::K_0_500_BIN_HI + lpm_pkg::RANGE_MARGIN_BIN);
		return raw > (lpm_pkg::K_0_500_BCD_HI + lpm_pkg::RANGE_MARGIN_BCD);
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic meas(input int l, input logic [15:0] raw);
		logic [15:0] w;
		@(negedge mclk);
		meas_raw[l*16 +: 16] = raw;
		meas_valid[l] = 1'b1;
		@(negedge mclk);
		meas_valid[l] = 1'b0;
		errs[l] = over(raw);
		lpm_host_model_i.read(pv_ofs[l], w);
		chk(w, errs[l] ? lpm_pkg::PV_FAULT_PATTERN : raw);
		lpm_host_model_i.read(st_ofs[l], w);
		chk(w, {1'b0, errs[l], 14'h0});
		chk(ctrl_out, ctrl_demand & ~errs);
		chk(out_lamp, ctrl_demand & ~errs);
		chk(unit_fault_lamp, |errs);
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		chk(io_base, 16'd2010);
		chk(dm_base, 32'd20100);
		chk({fahrenheit, bcd_mode, k_low_range}, 3'b011);
		chk(run_lamp, 1'b1);
		// Boundary readings sit among the random ones
		for (int i = 0; i < 40; i++)
		begin
			ctrl_demand = 4'(nxt());
			meas(i % 4, (i % 5 == 3) ? 16'h5200 : (i % 5 == 4) ? 16'h5201 : 16'(nxt() % 32'h5200));
		end
		// Other switch settings: binary limits, Fahrenheit, and a type that never flags
		for (int m = 1; m < 5; m++)
		begin
			{temp_unit_sw, data_format_sw} = 2'(m);
			input_type = (m == 3) ? 4'h0 : lpm_pkg::INPUT_K_0_500;
			repeat (2) @(negedge mclk);
			chk({fahrenheit, bcd_mode, k_low_range}, {temp_unit_sw, !data_format_sw, m != 3});
			for (int i = 0; i < 8; i++)
				meas(i % 4, (i % 4 == 1) ? 16'h1450 : (i % 4 == 2) ? 16'h1451 : 16'(nxt()));
		end
		for (int k = 7; k >= 0; k--)
		begin
			{control_stopped, host_error, init_error} = 3'(k);
			repeat (2) @(negedge mclk);
			chk(run_lamp, !control_stopped);
			chk(host_fault_lamp, host_error);
			chk(unit_fault_lamp, init_error | (|errs));
			chk(ctrl_out, control_stopped ? 4'h0 : ctrl_demand & ~errs);
			chk(out_lamp, control_stopped ? 4'h0 : ctrl_demand & ~errs);
		end
		for (int u = 0; u < 6; u++)
		begin
			unit_number = (u == 5) ? 7'd94 : 7'(nxt() % 95);
			repeat (2) @(negedge mclk);
			chk(io_base, 16'd2000 + 16'd10 * unit_number);
			chk(dm_base, 32'd20000 + 32'd100 * unit_number);
		end
		conclude();
	end
	// Whole run needs well under a tenth of this
	initial
	begin
		#200000;
		n_errors++;
		conclude();
	end
endmodule
`default_nettype wire
